// File: hdl/pim_pkg.sv
// package: constants, types and helpers of the psk transmit back end
package pim_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned SYM_RATE_LOW  = 150;
   localparam int unsigned SYM_RATE_HIGH = 600;
   localparam int unsigned SYM_CYC_LOW   = CLK_HZ / SYM_RATE_LOW;
   localparam int unsigned SYM_CYC_HIGH  = CLK_HZ / SYM_RATE_HIGH;
   localparam int unsigned TEST_CAR_MS   = 500;
   localparam int unsigned TEST_CAR_CYC  = (CLK_HZ / 1000) * TEST_CAR_MS;
   localparam int unsigned SHORT_COLS    = 16;
   localparam int unsigned SHORT_ROWS    = 24;
   localparam int unsigned LONG_COLS     = 24;
   localparam int unsigned LONG_ROWS     = 32;
   localparam int unsigned LONG_CELLS    = LONG_COLS * LONG_ROWS;
   localparam int unsigned MAX_MSG_BITS  = 126_000;
   localparam logic [13:0] MAX_MSG_BYTES = 14'(MAX_MSG_BITS / 8);
   localparam int unsigned FLUSH_BITS    = 16;
   localparam logic [7:0]  EOT_TEXT      = 8'h04;
   localparam logic [28:0] EOT_BIN       = 29'h18F2BD04;
   // end code then flush zeros, shifted out low bits first
   localparam logic [45:0] EOT_TEXT_SR   = 46'(EOT_TEXT);
   localparam logic [45:0] EOT_BIN_SR    = 46'(EOT_BIN);
   localparam logic [4:0]  EOT_TEXT_PRS  = 5'((8 + FLUSH_BITS) / 2);
   localparam logic [4:0]  EOT_BIN_PRS   = 5'((29 + FLUSH_BITS + 1) / 2);

   typedef enum logic [1:0] {FMT_BIN = 2'h1, FMT_TEXT = 2'h2, FMT_PSEUDO = 2'h3} pim_fmt_e;
   typedef enum logic [1:0] {ILV_NONE = 2'h0, ILV_SHORT = 2'h1, ILV_LONG = 2'h2} pim_ilv_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_DATA = 3'h1, ST_EOT = 3'h3,
      ST_PAD = 3'h2, ST_DRAIN = 3'h6, ST_TEST = 3'h4
   } pim_state_e;
   typedef struct packed {
      pim_fmt_e fmt;
      pim_ilv_e ilv;
      logic     hi_rate;
   } pim_cfg_s;

   // coded symbol to phase index, phase = index * 45 degrees
   function automatic logic [2:0] pim_phase(input logic [2:0] s);
      logic [2:0] p;
      p = {s[2], s[1], s[1] ^ s[0]};
      return p;
   endfunction : pim_phase

   function automatic logic [5:0] pim_rows(input pim_ilv_e m);
      return (m == ILV_LONG) ? 6'(LONG_ROWS) : 6'(SHORT_ROWS);
   endfunction : pim_rows

   function automatic logic [5:0] pim_cols(input pim_ilv_e m);
      return (m == ILV_LONG) ? 6'(LONG_COLS) : 6'(SHORT_COLS);
   endfunction : pim_cols
endpackage : pim_pkg

// File: hdl/pim_tx_mapper.sv
// psk transmit back end: pair feed, end code, interleaver, phase map, pacing
`timescale 1ns/1ps
module pim_tx_mapper
   import pim_pkg::*;
#(
   parameter int unsigned SYM_CYC_LOW_P  = SYM_CYC_LOW,
   parameter int unsigned SYM_CYC_HIGH_P = SYM_CYC_HIGH,
   parameter int unsigned TEST_CAR_CYC_P = TEST_CAR_CYC
) (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic       start_i,
   input  wire logic       test_mode_i,
   input  wire pim_cfg_s   cfg_i,
   input  wire logic [7:0] byte_i,
   input  wire logic       byte_valid_i,
   input  wire logic       byte_last_i,
   output logic            byte_ready_o,
   output logic [1:0]      pair_o,
   output logic            pair_valid_o,
   input  wire logic       pair_ready_i,
   input  wire logic [2:0] sym_i,
   input  wire logic       sym_valid_i,
   output logic            sym_ready_o,
   output logic [2:0]      phase_o,
   output logic            sym_strobe_o,
   output logic            carrier_on_o,
   output logic            len_err_o
);
   pim_state_e  st_r, st_nxt;
   pim_cfg_s    cfg_r;
   logic [7:0]  byte_sr_r;
   logic [2:0]  left_r;
   logic        last_r, byte_rdy_r, len_err_r;
   logic [13:0] byte_cnt_r;
   logic [45:0] eot_sr_r;
   logic [4:0]  eot_left_r;
   logic [1:0]  pair_r;
   logic        pair_vld_r;
   logic [9:0]  blk_cnt_r;
   logic [11:0] inflight_r;
   logic [2:0]  buf_q [2];
   logic        buf_wr_r, buf_rd_r, sym_rdy_r;
   logic [1:0]  buf_cnt_r, buf_cnt_nxt;
   logic [2:0]  ilv_mem [LONG_CELLS];
   logic [9:0]  wr_cnt_r;
   logic        rd_mode_r;
   logic [4:0]  col_r, row_r;
   logic [23:0] per_r, car_r;
   logic [2:0]  phase_r;
   logic        strobe_r, car_on_r;
   logic        emit;
   logic [1:0]  emit_pair;

   // shared decode
   wire         start_go  = start_i && (st_r == ST_IDLE);
   wire         use_ilv   = (cfg_r.ilv != ILV_NONE);
   wire         slot_free = !pair_vld_r || pair_ready_i;
   wire         pair_hs   = pair_vld_r && pair_ready_i;
   wire         byte_acc  = byte_valid_i && byte_rdy_r;
   wire [5:0]   rows      = pim_rows(cfg_r.ilv);
   wire [5:0]   cols      = pim_cols(cfg_r.ilv);
   wire [9:0]   cells     = 10'(rows) * 10'(cols);
   wire [9:0]   rd_addr   = 10'(col_r) * 10'(rows) + 10'(row_r);
   wire         tick      = (per_r == 24'h000000) && (st_r != ST_IDLE);
   wire         src_vld   = use_ilv ? rd_mode_r : (buf_cnt_r != 2'h0);
   wire [2:0]   buf_head  = buf_q[buf_rd_r];
   wire [2:0]   src_sym   = use_ilv ? ilv_mem[rd_addr] : buf_head;
   wire         tx_go     = tick && src_vld && (st_r != ST_TEST);
   wire         buf_push  = sym_valid_i && sym_rdy_r;
   // direct path drains the buffer only at symbol ticks
   wire         buf_pop   = use_ilv ? (!rd_mode_r && buf_cnt_r != 2'h0) : tx_go;
   wire         rd_last   = (col_r == 5'(cols - 6'h01)) && (row_r == 5'(rows - 6'h01));
   wire [23:0]  per_len   = cfg_r.hi_rate ? 24'(SYM_CYC_HIGH_P) : 24'(SYM_CYC_LOW_P);

   // message sequencer and pair selection
   always_comb begin
      st_nxt    = st_r;
      emit      = 1'b0;
      emit_pair = 2'h0;
      case (st_r)
         ST_IDLE: if (start_i) st_nxt = test_mode_i ? ST_TEST : ST_DATA;
         ST_DATA: begin
            if (left_r != 3'h0) begin
               emit      = slot_free;
               emit_pair = byte_sr_r[1:0];
            end else if (last_r) begin
               st_nxt = ST_EOT;
            end
         end
         ST_EOT: begin
            if (eot_left_r != 5'h00) begin
               emit      = slot_free;
               emit_pair = eot_sr_r[1:0];
            end else begin
               st_nxt = (use_ilv && blk_cnt_r != 10'h000) ? ST_PAD : ST_DRAIN;
            end
         end
         ST_PAD: begin
            if (blk_cnt_r == 10'h000) st_nxt = ST_DRAIN;
            else emit = slot_free;
         end
         // the last symbol keeps its full period before the carrier drops
         ST_DRAIN: if (inflight_r == 12'h000 && !pair_vld_r && tick) st_nxt = ST_IDLE;
         ST_TEST: if (!test_mode_i) st_nxt = ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   // state and configuration capture
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         st_r  <= ST_IDLE;
         cfg_r <= '{fmt: FMT_TEXT, ilv: ILV_NONE, hi_rate: 1'b0};
      end else begin
         st_r <= st_nxt;
         // format and interleaver chosen per message
         if (start_go) cfg_r <= cfg_i;
      end
   end

   // byte intake; a stalled pair keeps the byte in place
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || start_go) begin
         byte_sr_r  <= 8'h00;
         left_r     <= 3'h0;
         last_r     <= 1'b0;
         byte_cnt_r <= 14'h0000;
         len_err_r  <= 1'b0;
      end else if (byte_acc) begin
         byte_sr_r  <= byte_i;
         left_r     <= 3'h4;
         byte_cnt_r <= byte_cnt_r + 14'h0001;
         // force the end once the length limit is reached
         last_r     <= byte_last_i || (byte_cnt_r == MAX_MSG_BYTES - 14'h0001);
         len_err_r  <= !byte_last_i && (byte_cnt_r == MAX_MSG_BYTES - 14'h0001);
      end else if (emit && st_r == ST_DATA) begin
         byte_sr_r <= {2'h0, byte_sr_r[7:2]};
         left_r    <= left_r - 3'h1;
      end
   end

   // ready for a byte once the previous one is fully paired out
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) byte_rdy_r <= 1'b0;
      else byte_rdy_r <= (st_nxt == ST_DATA) && (start_go || (!byte_acc && !last_r
                         && (left_r == 3'h0 || (left_r == 3'h1 && emit))));
   end

   // end code and flush bits, loaded per format at start
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         eot_sr_r   <= 46'h0;
         eot_left_r <= 5'h00;
      end else if (start_go) begin
         // long code for binary, short code otherwise
         eot_sr_r   <= (cfg_i.fmt == FMT_BIN) ? EOT_BIN_SR : EOT_TEXT_SR;
         // pair count includes sixteen flush zeros
         eot_left_r <= (cfg_i.fmt == FMT_BIN) ? EOT_BIN_PRS : EOT_TEXT_PRS;
      end else if (emit && st_r == ST_EOT) begin
         eot_sr_r   <= {2'h0, eot_sr_r[45:2]};
         eot_left_r <= eot_left_r - 5'h01;
      end
   end

   // pair output register toward the encoder
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pair_r     <= 2'h0;
         pair_vld_r <= 1'b0;
      end else if (emit) begin
         pair_r     <= emit_pair;
         pair_vld_r <= 1'b1;
      end else if (pair_ready_i) begin
         pair_vld_r <= 1'b0;
      end
   end

   // block position of pairs, padding runs until it wraps
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || start_go) blk_cnt_r <= 10'h000;
      else if (emit) blk_cnt_r <= (blk_cnt_r == cells - 10'h001) ? 10'h000 : blk_cnt_r + 10'h001;
   end

   // symbols owed: pairs handed over minus symbols sent
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || start_go) inflight_r <= 12'h000;
      else inflight_r <= inflight_r + {11'h000, pair_hs} - {11'h000, tx_go};
   end

   // two-entry buffer between encoder and interleaver
   assign buf_cnt_nxt = buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         buf_wr_r  <= 1'b0;
         buf_rd_r  <= 1'b0;
         buf_cnt_r <= 2'h0;
         sym_rdy_r <= 1'b0;
      end else begin
         buf_wr_r  <= buf_wr_r ^ buf_push;
         buf_rd_r  <= buf_rd_r ^ buf_pop;
         buf_cnt_r <= buf_cnt_nxt;
         sym_rdy_r <= (buf_cnt_nxt != 2'h2);
      end
   end
   // buffer storage has no reset: an entry is read only once counted
   always_ff @(posedge clk_sys_i) begin
      if (buf_push) buf_q[buf_wr_r] <= sym_i;
   end

   // interleaver storage, written in column-major address order
   always_ff @(posedge clk_sys_i) begin
      if (use_ilv && buf_pop) ilv_mem[wr_cnt_r] <= buf_head;
   end

   // block size follows the selected interleaver
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || start_go) begin
         // first symbol lands in the first cell
         wr_cnt_r  <= 10'h000;
         rd_mode_r <= 1'b0;
         col_r     <= 5'h00;
         row_r     <= 5'h00;
      end else if (use_ilv && buf_pop) begin
         // address = column * rows + row, so a column fills before the next
         wr_cnt_r  <= wr_cnt_r + 10'h001;
         rd_mode_r <= (wr_cnt_r == cells - 10'h001);
      end else if (use_ilv && tx_go) begin
         // walk columns of one row, then the next row
         if (rd_last) begin
            rd_mode_r <= 1'b0;
            wr_cnt_r  <= 10'h000;
            col_r     <= 5'h00;
            row_r     <= 5'h00;
         end else if (col_r == 5'(cols - 6'h01)) begin
            col_r <= 5'h00;
            row_r <= row_r + 5'h01;
         end else begin
            col_r <= col_r + 5'h01;
         end
      end
   end

   // symbol period timer; carrier hold counter
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || st_r == ST_IDLE) begin
         per_r <= 24'h000000;
         car_r <= 24'(TEST_CAR_CYC_P - 1);
      end else begin
         per_r <= (per_r == 24'h000000) ? per_len - 24'h000001 : per_r - 24'h000001;
         if (car_r != 24'h000000) car_r <= car_r - 24'h000001;
      end
   end

   // phase register; idle and carrier-only both sit at zero degrees
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || st_nxt == ST_IDLE) begin
         phase_r  <= 3'h0;
         strobe_r <= 1'b0;
      end else if (st_r == ST_TEST) begin
         // carrier first, then 0/180 toggling each symbol
         strobe_r <= tick && (car_r == 24'h000000);
         if (tick && car_r == 24'h000000) phase_r <= phase_r ^ 3'h4;
      end else begin
         strobe_r <= tx_go;
         if (tx_go) phase_r <= pim_phase(src_sym);
      end
   end

   // carrier flag follows the next state so it drops with the phase
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) car_on_r <= 1'b0;
      else car_on_r <= (st_nxt != ST_IDLE);
   end

   assign byte_ready_o = byte_rdy_r;
   assign pair_o       = pair_r;
   assign pair_valid_o = pair_vld_r;
   assign sym_ready_o  = sym_rdy_r;
   assign phase_o      = phase_r;
   assign sym_strobe_o = strobe_r;
   assign carrier_on_o = car_on_r;
   assign len_err_o    = len_err_r;

   chk_phase_map: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (tx_go && st_nxt != ST_IDLE) |=> phase_o == pim_phase($past(src_sym)))
      else $error("phase does not match coded symbol");
   chk_pair_order: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_r == ST_DATA && left_r == 3'h4 && emit) |=> pair_o == $past(byte_sr_r[1:0]))
      else $error("byte did not start with low pair");
   chk_eot_first: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_r == ST_EOT && eot_left_r == EOT_TEXT_PRS && cfg_r.fmt != FMT_BIN && emit)
      |=> pair_o == EOT_TEXT[1:0] ##0 pair_valid_o)
      else $error("end code first pair wrong");
   chk_pad_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_r == ST_PAD && emit) |=> pair_o == 2'h0 && pair_valid_o)
      else $error("padding pair not zero");
   chk_no_pad: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      st_r == ST_PAD |-> use_ilv)
      else $error("padding without interleaver");
   chk_row_walk: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (use_ilv && tx_go && !rd_last && col_r == 5'(cols - 6'h01))
      |=> col_r == 5'h00 && row_r == $past(row_r) + 5'h01)
      else $error("row-major read order broken");
   chk_fill_start: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      start_go |=> wr_cnt_r == 10'h000 && !rd_mode_r)
      else $error("interleaver not reset at message start");
   chk_sym_spacing: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      tick |=> !tick [*8])
      else $error("symbol ticks too close");
   chk_len_limit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      byte_cnt_r <= MAX_MSG_BYTES && !(byte_rdy_r && byte_cnt_r == MAX_MSG_BYTES))
      else $error("message length limit exceeded");
   chk_test_carrier: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (st_r == ST_TEST && car_r != 24'h000000) |-> phase_o == 3'h0)
      else $error("carrier phase not zero during hold");
endmodule : pim_tx_mapper

// File: bench/pim_enc_model.sv
// behavioural model of the external scrambler and trellis encoder
`timescale 1ns/1ps
module pim_enc_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       slow_i,
   input  wire logic [1:0] pair_i,
   input  wire logic       pair_valid_i,
   output logic            pair_ready_o,
   output logic [2:0]      sym_o,
   output logic            sym_valid_o,
   input  wire logic       sym_ready_i
);
   logic [2:0] q[$];
   logic [2:0] k = 3'h0;
   logic [3:0] cyc = 4'h0;
   initial begin
      pair_ready_o = 1'b0;
      sym_o = 3'h0;
      sym_valid_o = 1'b0;
   end
   // symbol value is the pair count modulo 8, so a cell is traced only by its address modulo 8
   always @(posedge clk_i) begin
      cyc <= cyc + 4'h1;
      if (rst_i) begin
         q.delete();
         k = 3'h0;
      end else begin
         if (sym_valid_o && sym_ready_i)
            void'(q.pop_front());
         if (pair_valid_i && pair_ready_o) begin
            q.push_back(k);
            k = k + 3'h1;
         end
      end
   end
   // slow mode stalls both sides; a raised valid stays until taken
   always @(negedge clk_i) begin
      pair_ready_o <= !rst_i && (!slow_i || cyc[1:0] == 2'h3);
      if (q.size() > 0 && (sym_valid_o || !slow_i || cyc[2])) begin
         sym_valid_o <= 1'b1;
         sym_o <= q[0];
      end else begin
         sym_valid_o <= 1'b0;
         sym_o <= ~sym_o; // no stale symbol when idle
      end
   end
endmodule : pim_enc_model

// File: bench/pim_tx_mapper_tb.sv
// self-checking bench for the psk transmit back end
`timescale 1ns/1ps
module pim_tx_mapper_tb;
   import pim_pkg::*;
   localparam int unsigned LOW_P  = 40;
   localparam int unsigned HIGH_P = 12;
   localparam int unsigned CAR_P  = 50;
   // phase index per coded symbol, degrees over 45
   localparam logic [2:0] PH_TAB [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h5, 3'h7, 3'h6};
   logic       clk_sys_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       start_i = 1'b0;
   logic       test_mode_i = 1'b0;
   pim_cfg_s   cfg_i = '0;
   logic [7:0] byte_i = 8'h00;
   logic       byte_valid_i = 1'b0;
   logic       byte_last_i = 1'b0;
   logic       slow = 1'b0;
   logic       byte_ready_o, pair_valid_o, pair_ready_i, sym_valid_i, sym_ready_o;
   logic       sym_strobe_o, carrier_on_o, len_err_o;
   logic [1:0] pair_o;
   logic [2:0] sym_i, phase_o;
   logic [1:0] got_pair[$];
   logic [1:0] exp_pair[$];
   logic [2:0] got_ph[$];
   int         errors = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   int         last_t = 0;
   int         first_t = 0;
   int         per = 12;

   always #25 clk_sys_i = ~clk_sys_i;

   pim_tx_mapper #(.SYM_CYC_LOW_P(LOW_P), .SYM_CYC_HIGH_P(HIGH_P), .TEST_CAR_CYC_P(CAR_P)) u_dut (
      .clk_sys_i, .sys_rst_i, .start_i, .test_mode_i, .cfg_i, .byte_i, .byte_valid_i,
      .byte_last_i, .byte_ready_o, .pair_o, .pair_valid_o, .pair_ready_i, .sym_i,
      .sym_valid_i, .sym_ready_o, .phase_o, .sym_strobe_o, .carrier_on_o, .len_err_o);

   pim_enc_model u_enc (.clk_i(clk_sys_i), .rst_i(sys_rst_i), .slow_i(slow), .pair_i(pair_o),
      .pair_valid_i(pair_valid_o), .pair_ready_o(pair_ready_i), .sym_o(sym_i),
      .sym_valid_o(sym_valid_i), .sym_ready_i(sym_ready_o));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // record pairs and phases; ticks are free running, so gaps are whole periods
   always @(posedge clk_sys_i) begin
      cyc = cyc + 1;
      if (pair_valid_o && pair_ready_i)
         got_pair.push_back(pair_o);
      if (sym_strobe_o) begin
         got_ph.push_back(phase_o);
         if (last_t != 0)
            check("strobe gap", 32'((cyc - last_t) % per), 32'h0);
         if (first_t == 0)
            first_t = cyc;
         last_t = cyc;
      end
   end

   task automatic do_reset;
      @(negedge clk_sys_i);
      sys_rst_i = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      got_pair.delete();
      exp_pair.delete();
      got_ph.delete();
      last_t = 0;
      first_t = 0;
      @(negedge clk_sys_i);
   endtask : do_reset

   // bounded wait for the carrier to drop; a hang ends the run
   task automatic wait_off(input int lim);
      int n;
      n = 0;
      while (carrier_on_o !== 1'b0 && n < lim) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= lim) begin
         check("carrier off", 32'h0, 32'h1);
         complete_run();
      end
   endtask : wait_off

   task automatic send_byte(input logic [7:0] b, input logic last);
      int n;
      byte_i = b;
      byte_last_i = last;
      byte_valid_i = 1'b1;
      n = 0;
      // ready is registered: a high level seen here still stands at the next rising edge
      while (byte_ready_o !== 1'b1 && n < 2000) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 2000) begin
         check("byte taken", 32'h0, 32'h1);
         complete_run();
      end
      @(negedge clk_sys_i);
      // valid stays up between bytes of one message, so it never toggles in one step
      if (last) begin
         byte_valid_i = 1'b0;
         byte_last_i = 1'b0;
      end
   endtask : send_byte

   function automatic void push_bits(input logic [45:0] v, input int npairs);
      for (int i = 0; i < npairs; i++)
         exp_pair.push_back(v[2*i +: 2]);
   endfunction : push_bits

   task automatic run_msg(input string name, input pim_fmt_e f, input pim_ilv_e m,
                          input logic hi, input logic [7:0] b0, input logic [7:0] b1);
      int cols, rows, cells, k;
      cols = (m == ILV_LONG) ? 24 : 16;
      rows = (m == ILV_LONG) ? 32 : 24;
      cells = (m == ILV_NONE) ? 1 : cols * rows;
      per = hi ? HIGH_P : LOW_P;
      do_reset();
      cfg_i = '{fmt: f, ilv: m, hi_rate: hi};
      start_i = 1'b1;
      @(negedge clk_sys_i);
      start_i = 1'b0;
      // payload holds no reserved control codes
      send_byte(b0, 1'b0);
      send_byte(b1, 1'b1);
      wait_off(40000);
      push_bits(46'(b0), 4);
      push_bits(46'(b1), 4);
      if (f == FMT_BIN)
         push_bits(46'(29'h18F2BD04), 23); // long end code, flush, one spare zero
      else
         push_bits(46'(8'h04), 12);
      while (exp_pair.size() % cells != 0)
         exp_pair.push_back(2'h0);
      check({name, " pairs"}, 32'(got_pair.size()), 32'(exp_pair.size()));
      foreach (exp_pair[i])
         check("pair", 32'(got_pair[i]), 32'(exp_pair[i]));
      check({name, " symbols"}, 32'(got_ph.size()), 32'(exp_pair.size()));
      // column-major cell of each row-major read, symbol carries its cell modulo 8
      for (int j = 0; j < got_ph.size(); j++) begin
         k = (m == ILV_NONE) ? j : (j / cells) * cells + (j % cols) * rows + (j % cells) / cols;
         check("phase", 32'(got_ph[j]), 32'(PH_TAB[3'(k)]));
      end
      check("end phase", 32'(phase_o), 32'h0);
      check("length error", 32'(len_err_o), 32'h0);
      $display("test %s done", name);
   endtask : run_msg

   task automatic run_test_mode;
      int t0;
      per = HIGH_P;
      do_reset();
      cfg_i = '{fmt: FMT_TEXT, ilv: ILV_NONE, hi_rate: 1'b1};
      test_mode_i = 1'b1;
      start_i = 1'b1;
      t0 = cyc;
      @(negedge clk_sys_i);
      start_i = 1'b0;
      repeat (CAR_P + 8 * HIGH_P) @(negedge clk_sys_i);
      check("test carrier", 32'(carrier_on_o), 32'h1);
      test_mode_i = 1'b0;
      wait_off(200);
      check("quiet carrier", 32'(first_t - t0 >= CAR_P), 32'h1);
      check("toggle start", 32'(first_t - t0 <= CAR_P + 2 * HIGH_P + 4), 32'h1);
      check("toggles", 32'(got_ph.size() >= 6), 32'h1);
      for (int i = 0; i < got_ph.size(); i++)
         check("test phase", 32'(got_ph[i]), (i % 2) ? 32'h0 : 32'h4);
      $display("test symbol rate pattern done");
   endtask : run_test_mode

   initial begin
      do_reset();
      check("ready at reset", 32'(byte_ready_o), 32'h0);
      check("pair valid at reset", 32'(pair_valid_o), 32'h0);
      check("sym ready at reset", 32'(sym_ready_o), 32'h1);
      check("carrier at reset", 32'(carrier_on_o), 32'h0);
      check("phase at reset", 32'(phase_o), 32'h0);
      // every payload format, each interleaver choice and both rates
      run_msg("text plain", FMT_TEXT, ILV_NONE, 1'b1, 8'hB4, 8'h5A);
      slow = 1'b1;
      run_msg("binary short", FMT_BIN, ILV_SHORT, 1'b0, 8'h6C, 8'hA3);
      slow = 1'b0;
      run_msg("pseudo long", FMT_PSEUDO, ILV_LONG, 1'b1, 8'h41, 8'h3D);
      run_test_mode();
      complete_run();
   end
endmodule : pim_tx_mapper_tb
